//--- cmtw_pkg.sv
package cmtw_pkg;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int          CntWidth       = 16;
  localparam logic [15:0] CounterReset   = 16'h0000;
  localparam logic [15:0] PeriodReset    = 16'hffff;
  localparam logic [15:0] CountOne       = 16'h0001;

  // ----------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------
  localparam int          PreWidth       = 9;
  localparam logic [8:0]  PreZero        = 9'h000;
  localparam logic [8:0]  PreOne         = 9'h001;
  localparam logic [8:0]  PreMaskDiv8    = 9'h007;
  localparam logic [8:0]  PreMaskDiv32   = 9'h01f;
  localparam logic [8:0]  PreMaskDiv128  = 9'h07f;
  localparam logic [8:0]  PreMaskDiv512  = 9'h1ff;

  typedef enum logic [1:0] {
    CMTW_DIV8   = 2'b00,
    CMTW_DIV32  = 2'b01,
    CMTW_DIV128 = 2'b10,
    CMTW_DIV512 = 2'b11
  } cmtw_div_t;

  // ----------------------------------------------------------------------
  // counter write request from the peripheral bus
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        commit;
    logic        wrHi;
    logic        wrLo;
    logic [15:0] data;
  } cmtw_cnt_wr_t;

  typedef enum logic [1:0] {
    CMTW_BUS_IDLE = 2'b00,
    CMTW_BUS_T1   = 2'b01,
    CMTW_BUS_T2   = 2'b10
  } cmtw_bus_state_t;

endpackage : cmtw_pkg

//--- cmtw_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module cmtw_prescaler (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              countRun,
  input  wire cmtw_pkg::cmtw_div_t divSelect,
  output logic                   countTick
);

  logic [cmtw_pkg::PreWidth-1:0] preCnt_reg;
  logic [cmtw_pkg::PreWidth-1:0] preCnt_next;
  logic [cmtw_pkg::PreWidth-1:0] preMask;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (divSelect)
      cmtw_pkg::CMTW_DIV8:   preMask = cmtw_pkg::PreMaskDiv8;
      cmtw_pkg::CMTW_DIV32:  preMask = cmtw_pkg::PreMaskDiv32;
      cmtw_pkg::CMTW_DIV128: preMask = cmtw_pkg::PreMaskDiv128;
      cmtw_pkg::CMTW_DIV512: preMask = cmtw_pkg::PreMaskDiv512;
    endcase
  end

  // stopped prescaler restarts from zero so the first tick is a full period
  always_comb begin
    if (!countRun) begin
      preCnt_next = cmtw_pkg::PreZero;
    end else begin
      preCnt_next = preCnt_reg + cmtw_pkg::PreOne;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      preCnt_reg <= cmtw_pkg::PreZero;
    end else begin
      preCnt_reg <= preCnt_next;
    end
  end

  // tick on the last count of each divided period
  assign countTick = countRun && ((preCnt_reg & preMask) == preMask);

endmodule : cmtw_prescaler

`default_nettype wire

//--- cmtw_timer.sv
// Notes on behaviour
// - A compare match in the commit cycle of a counter write clears the counter and the write data is dropped.
// - An increment in the commit cycle of a word write is lost and the written word is loaded.
// - An increment in the commit cycle of a byte write leaves the written byte exactly as written.
// - The unwritten byte of a colliding byte write keeps its pre-write value with no carry.
// - While running, the counter advances once per tick of the clock divided by 8, 32, 128 or 512 per the select code.
// - When the counter equals the period it returns to zero, sets the match flag and counts on from zero.
// - The match interrupt is asserted only while the match flag and its enable are both set.
// - After reset the counter reads zero and the period reads all ones.
`timescale 1ns/1ps
`default_nettype none

module cmtw_timer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        countRun,
  input  wire logic        dividerSelectHi,
  input  wire logic        dividerSelectLo,
  input  wire logic        matchIrqEnable,
  input  wire logic        busReq,
  input  wire logic        busWrHi,
  input  wire logic        busWrLo,
  input  wire logic [15:0] busWrData,
  input  wire logic        periodWr,
  input  wire logic [15:0] periodWrData,
  input  wire logic        matchFlagClear,
  output logic [15:0]      upCounter,
  output logic [15:0]      periodConstant,
  output logic             matchFlag,
  output logic             matchInterrupt,
  output logic             busBusy
);

  cmtw_pkg::cmtw_div_t             divSelect;
  logic                            countTick;
  cmtw_pkg::cmtw_bus_state_t       busState_reg;
  cmtw_pkg::cmtw_bus_state_t       busState_next;
  cmtw_pkg::cmtw_cnt_wr_t          wrHold_reg;
  cmtw_pkg::cmtw_cnt_wr_t          wrHold_next;
  cmtw_pkg::cmtw_cnt_wr_t          wrNow;
  logic [15:0]                     cnt_reg;
  logic [15:0]                     cnt_next;
  logic [15:0]                     period_reg;
  logic [15:0]                     period_next;
  logic                            flag_reg;
  logic                            flag_next;
  logic                            matchPend_reg;
  logic                            matchPend_next;
  logic                            compareMatch;

  assign divSelect = cmtw_pkg::cmtw_div_t'({dividerSelectHi, dividerSelectLo});

  cmtw_prescaler u_prescaler (
    .core_clk  (core_clk),
    .rst       (rst),
    .countRun  (countRun),
    .divSelect (divSelect),
    .countTick (countTick)
  );

  // ----------------------------------------------------------------------
  // bus write cycle: T1 latches the request, T2 commits it
  // ----------------------------------------------------------------------
  always_comb begin
    busState_next = busState_reg;
    wrHold_next   = wrHold_reg;
    unique case (busState_reg)
      cmtw_pkg::CMTW_BUS_IDLE: begin
        if (busReq && (busWrHi || busWrLo)) begin
          busState_next     = cmtw_pkg::CMTW_BUS_T1;
          wrHold_next.wrHi  = busWrHi;
          wrHold_next.wrLo  = busWrLo;
          wrHold_next.data  = busWrData;
        end
      end
      cmtw_pkg::CMTW_BUS_T1: begin
        busState_next = cmtw_pkg::CMTW_BUS_T2;
      end
      cmtw_pkg::CMTW_BUS_T2: begin
        busState_next = cmtw_pkg::CMTW_BUS_IDLE;
      end
      default: begin
        busState_next = cmtw_pkg::CMTW_BUS_IDLE;
      end
    endcase
    wrHold_next.commit = 1'b0;
  end

  always_comb begin
    wrNow        = wrHold_reg;
    wrNow.commit = (busState_reg == cmtw_pkg::CMTW_BUS_T2);
  end

  assign busBusy = (busState_reg != cmtw_pkg::CMTW_BUS_IDLE);

  // ----------------------------------------------------------------------
  // counter, match and contention
  // ----------------------------------------------------------------------
  // the match signal fires on the tick that would move past the match value,
  // so a match written by software only takes effect at the next input clock
  assign compareMatch = countTick && (cnt_reg == period_reg);

  always_comb begin
    cnt_next = cnt_reg;
    if (compareMatch) begin
      cnt_next = cmtw_pkg::CounterReset;
    end else if (wrNow.commit) begin
      // write wins over a tick; unwritten byte keeps its old value
      cnt_next[15:8] = wrNow.wrHi ? wrNow.data[15:8] : cnt_reg[15:8];
      cnt_next[7:0]  = wrNow.wrLo ? wrNow.data[7:0]  : cnt_reg[7:0];
    end else if (countTick) begin
      cnt_next = cnt_reg + cmtw_pkg::CountOne;
    end
  end

  always_comb begin
    period_next    = periodWr ? periodWrData : period_reg;
    matchPend_next = compareMatch;
    // a fresh match beats a simultaneous clear
    if (matchPend_reg) begin
      flag_next = 1'b1;
    end else if (matchFlagClear) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busState_reg  <= cmtw_pkg::CMTW_BUS_IDLE;
      wrHold_reg    <= '0;
      cnt_reg       <= cmtw_pkg::CounterReset;
      period_reg    <= cmtw_pkg::PeriodReset;
      flag_reg      <= 1'b0;
      matchPend_reg <= 1'b0;
    end else begin
      busState_reg  <= busState_next;
      wrHold_reg    <= wrHold_next;
      cnt_reg       <= cnt_next;
      period_reg    <= period_next;
      flag_reg      <= flag_next;
      matchPend_reg <= matchPend_next;
    end
  end

  assign upCounter      = cnt_reg;
  assign periodConstant = period_reg;
  assign matchFlag      = flag_reg;
  assign matchInterrupt = flag_reg && matchIrqEnable;

endmodule : cmtw_timer

`default_nettype wire

//--- cmtw_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// contention and counting checks
// ------------------------------------
module cmtw_timer_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        matchIrqEnable,
  input wire logic        busReq,
  input wire logic        busWrHi,
  input wire logic        busWrLo,
  input wire logic [15:0] busWrData,
  input wire logic        matchFlagClear,
  input wire logic [15:0] upCounter,
  input wire logic [15:0] periodConstant,
  input wire logic        matchFlag,
  input wire logic        matchInterrupt,
  input wire logic        busBusy
);
  wire take = busReq && !busBusy && (busWrHi || busWrLo);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  irq_level_a: assert property (
    matchInterrupt == (matchFlag && matchIrqEnable)) else $error("irq");
  reset_vals_a: assert property ($past(rst) |->
    upCounter == 16'h0000 && periodConstant == 16'hffff && !matchFlag)
    else $error("reset");
  bus_len_a: assert property (
    take |=> busBusy [*2] ##1 !busBusy) else $error("busy");
  word_wr_a: assert property (take && busWrHi && busWrLo |->
    ##3 (upCounter == $past(busWrData, 3) || upCounter == 16'h0000))
    else $error("word");
  hi_byte_a: assert property (take && !busWrLo |-> ##3
    (upCounter[15:8] == $past(busWrData[15:8], 3) &&
     upCounter[7:0] == $past(upCounter[7:0])) || upCounter == 16'h0000)
    else $error("hi byte");
  lo_byte_a: assert property (take && !busWrHi |-> ##3
    (upCounter[7:0] == $past(busWrData[7:0], 3) &&
     upCounter[15:8] == $past(upCounter[15:8])) || upCounter == 16'h0000)
    else $error("lo byte");
  flag_set_a: assert property (
    $rose(matchFlag) |-> $past(upCounter) == 16'h0000) else $error("set");
  flag_hold_a: assert property (
    matchFlag && !matchFlagClear |=> matchFlag) else $error("hold");
  count_step_a: assert property (
    !busBusy && !$past(busBusy) && upCounter != $past(upCounter) |->
    upCounter == $past(upCounter) + 16'h0001 || upCounter == 16'h0000)
    else $error("step");
endmodule : cmtw_timer_asserts
bind cmtw_timer cmtw_timer_asserts chk (.core_clk, .rst, .matchIrqEnable,
  .busReq, .busWrHi, .busWrLo, .busWrData, .matchFlagClear, .upCounter,
  .periodConstant, .matchFlag, .matchInterrupt, .busBusy);
`default_nettype wire

//--- cmtw_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// bus master writing the counter
// ------------------------------------
module cmtw_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        busBusy,
  input  wire logic [15:0] upCounter,
  output logic             busReq,
  output logic             busWrHi,
  output logic             busWrLo,
  output logic [15:0]      busWrData
);
  initial {busReq, busWrHi, busWrLo, busWrData} = 19'h05a5a;
  // called at a falling edge while idle; returns counter seen in T2
  task automatic wr(input logic hi, input logic lo, input logic [15:0] d,
                    output logic [15:0] pre);
    {busReq, busWrHi, busWrLo, busWrData} = {1'b1, hi, lo, d};
    @(negedge core_clk);
    // released data lines show garbage, not the last value
    {busReq, busWrHi, busWrLo, busWrData} = {3'h0, ~d};
    @(negedge core_clk);
    pre = upCounter;
    @(negedge core_clk);
  endtask : wr
endmodule : cmtw_cpu_model
`default_nettype wire

//--- cmtw_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cmtw_timer_tb;
  logic        core_clk, rst, countRun, dividerSelectHi, dividerSelectLo;
  logic        matchIrqEnable, periodWr, matchFlagClear, matchFlag;
  logic        busReq, busWrHi, busWrLo, busBusy, matchInterrupt;
  logic [15:0] busWrData, periodWrData, upCounter, periodConstant, pre;
  int          mismatches = 0, compares = 0, n;
  cmtw_timer uut (.core_clk, .rst, .countRun, .dividerSelectHi,
    .dividerSelectLo, .matchIrqEnable, .busReq, .busWrHi, .busWrLo,
    .busWrData, .periodWr, .periodWrData, .matchFlagClear, .upCounter,
    .periodConstant, .matchFlag, .matchInterrupt, .busBusy);
  cmtw_cpu_model cpu (.core_clk, .busBusy, .upCounter, .busReq, .busWrHi,
    .busWrLo, .busWrData);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait at falling edges for a counter change or the flag
  task automatic wchg(output int cnt, input logic flg);
    logic [15:0] v;
    v = upCounter;
    cnt = 0;
    while (flg ? matchFlag !== 1'b1 : upCounter === v) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 1100) begin
        mismatches++;
        end_of_test;
      end
    end
  endtask : wchg
  initial begin
    {rst, countRun, dividerSelectHi, dividerSelectLo} = 4'h8;
    {matchIrqEnable, periodWr, matchFlagClear, periodWrData} = 19'h0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    chk(upCounter, 16'h0000);
    chk(periodConstant, 16'hffff);
    cpu.wr(1'b1, 1'b0, 16'hab00, pre);
    chk(upCounter, 16'hab00);
    cpu.wr(1'b0, 1'b1, 16'h00cd, pre);
    chk(upCounter, 16'habcd);
    for (int s = 0; s < 4; s++) begin
      {dividerSelectHi, dividerSelectLo} = s[1:0];
      countRun = 1'b1;
      wchg(n, 1'b0);
      wchg(n, 1'b0);
      chk(n[15:0], 16'h0008 << (2 * s));
      countRun = 1'b0;
    end
    {dividerSelectHi, dividerSelectLo, countRun} = 3'h1;
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk);
      cpu.wr(1'b1, 1'b1, 16'h0100 + k[15:0], pre);
      chk(upCounter, 16'h0100 + k[15:0]);
      cpu.wr(k[0], !k[0], 16'hc3ff, pre);
      chk(upCounter, k[0] ? {8'hc3, pre[7:0]} : {pre[15:8], 8'hff});
    end
    {periodWrData, periodWr, matchIrqEnable} = {16'h0002, 2'b11};
    @(negedge core_clk);
    periodWr = 1'b0;
    cpu.wr(1'b1, 1'b1, 16'h0000, pre);
    wchg(n, 1'b1);
    chk(upCounter, 16'h0000);
    chk({15'h0, matchInterrupt}, 16'h0001);
    matchIrqEnable = 1'b0;
    matchFlagClear = 1'b1;
    @(negedge core_clk);
    matchFlagClear = 1'b0;
    chk({15'h0, matchInterrupt}, 16'h0000);
    chk({15'h0, matchFlag}, 16'h0000);
    // align to a tick, make the next tick a match, land T2 on that tick
    for (int k = 0; k < 4; k++) begin
      wchg(n, 1'b0);
      {periodWrData, periodWr} = {upCounter, 1'b1};
      @(negedge core_clk);
      periodWr = 1'b0;
      repeat (4) @(negedge core_clk);
      cpu.wr(1'b1, 1'b1, 16'h1234, pre);
      chk(upCounter, 16'h0000);
      @(negedge core_clk);
      chk({15'h0, matchFlag}, 16'h0001);
      matchFlagClear = 1'b1;
      @(negedge core_clk);
      matchFlagClear = 1'b0;
    end
    end_of_test;
  end
endmodule : cmtw_timer_tb
`default_nettype wire
